/* File: core/dcf_pkg.sv */
/*
  Constants shared by the single-clock FIFO flag block: sizes, register
  offsets, field positions, reset values and timing counts.
  Assumes a 200 MHz aclk and a 32-bit AXI4-Lite register bus.
*/
package dcf_pkg;
  // ----------------------------------------
  // Storage geometry
  // ----------------------------------------
  localparam int DATA_W = 18;
  localparam int DEPTH = 64;
  localparam int PTR_W = 6;
  localparam int CNT_W = 7;
  localparam logic [CNT_W-1:0] DEPTH_CNT = 7'h40;
  localparam logic [PTR_W-1:0] PTR_LAST = 6'h3F;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_AE_OFFSET = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_AF_OFFSET = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h14;
  localparam int CTRL_ASYNC_BIT = 0;
  localparam int CTRL_ODIS_BIT = 1;
  localparam int CTRL_RETX_BIT = 2;
  localparam logic [CNT_W-1:0] AE_OFS_RST = 7'h08;
  localparam logic [CNT_W-1:0] AF_OFS_RST = 7'h08;
  localparam int ST_EMPTY_N = 0;
  localparam int ST_AE_N = 1;
  localparam int ST_AF_N = 2;
  localparam int ST_FULL_N = 3;
  localparam int ST_RETX_BUSY = 4;
  localparam int ST_CNT_LSB = 8;

  // ----------------------------------------
  // Interrupt status bits
  // ----------------------------------------
  localparam int IRQ_W = 6;
  localparam int IRQ_FULL = 0;
  localparam int IRQ_EMPTY = 1;
  localparam int IRQ_AF = 2;
  localparam int IRQ_AE = 3;
  localparam int IRQ_OVF = 4;
  localparam int IRQ_UNF = 5;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_PS = 5000;
  localparam int RETRANSMIT_RECOVERY_NS = 12;
  localparam logic [3:0] RETRANSMIT_RECOVERY_CYC =
    4'((RETRANSMIT_RECOVERY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: core/dcf_fifo.sv */
/*
  Single-clock FIFO with full, empty, programmable almost-full and
  almost-empty flags, cascade-out pulses, retransmit and AXI4-Lite control.
  Assumes write and read users sit on aclk and honour the flags.
*/
// The AXI4-Lite interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module dcf_fifo
  import dcf_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write side
  input wire logic wr_en,
  input wire logic [DATA_W-1:0] wr_data,
  output logic full_flag_n,
  output logic almost_full_flag_n,
  output logic write_cascade_out,
  // Read side
  input wire logic rd_en,
  output logic [DATA_W-1:0] rd_data,
  output logic rd_data_oe,
  output logic empty_flag_n,
  output logic almost_empty_flag_n,
  output logic read_cascade_out,
  // Interrupt
  output logic irq,
  // AXI4-Lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic ae_hit(input logic [CNT_W-1:0] cnt, input logic [CNT_W-1:0] off);
    ae_hit = cnt < off;
  endfunction

  function automatic logic af_hit(input logic [CNT_W-1:0] cnt, input logic [CNT_W-1:0] off);
    af_hit = ({1'b0, cnt} + {1'b0, off}) > {1'b0, DEPTH_CNT};
  endfunction

  function automatic logic [CNT_W-1:0] byte0(input logic [CNT_W-1:0] old,
                                           input logic [31:0] d, input logic [3:0] s);
    byte0 = s[0] ? d[CNT_W-1:0] : old;
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [DATA_W-1:0] mem_r [DEPTH];
  logic [PTR_W-1:0] wptr_r, rptr_r;
  logic [CNT_W-1:0] count_r, count_nxt, wr_total_r;
  logic [3:0] rtx_cnt_r;
  logic async_mode_r, out_disable_r;
  logic [CNT_W-1:0] ae_off_r, af_off_r;
  logic [IRQ_W-1:0] irq_stat_r, irq_mask_r, irq_set;
  logic aw_hold_r, w_hold_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic do_wr, ar_go, retx_go, rtx_busy, wr_ok, rd_ok;
  logic full_nxt_n, empty_nxt_n, ae_sel, af_sel;

  assign rtx_busy = rtx_cnt_r != 4'h0;
  assign do_wr = aw_hold_r & w_hold_r & ~s_axi_bvalid;
  assign ar_go = s_axi_arvalid & s_axi_arready;
  assign retx_go = do_wr & (awaddr_r == OFS_CTRL) & wstrb_r[0] & wdata_r[CTRL_RETX_BIT];
  assign wr_ok = wr_en & full_flag_n & ~retx_go;
  assign rd_ok = rd_en & empty_flag_n & ~rtx_busy & ~retx_go;

  // ----------------------------------------
  // Occupancy
  // ----------------------------------------
  always_comb begin
    if (retx_go) begin
      count_nxt = wr_total_r;
    end else begin
      count_nxt = count_r + CNT_W'(wr_ok) - CNT_W'(rd_ok);
    end
  end

  assign full_nxt_n = count_nxt != DEPTH_CNT;
  assign empty_nxt_n = count_nxt != 7'h00;
  // Async mode lags one edge; sync mode tracks the edge itself
  assign ae_sel = async_mode_r ? ~ae_hit(count_r, ae_off_r) : ~ae_hit(count_nxt, ae_off_r);
  assign af_sel = async_mode_r ? ~af_hit(count_r, af_off_r) : ~af_hit(count_nxt, af_off_r);

  always_ff @(posedge aclk) begin
    if (wr_ok) begin
      mem_r[wptr_r] <= wr_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wptr_r <= '0;
      rptr_r <= '0;
      count_r <= '0;
      wr_total_r <= '0;
    end else begin
      count_r <= count_nxt;
      if (wr_ok) begin
        wptr_r <= wptr_r + 6'h01;
      end
      if (wr_ok && wr_total_r != DEPTH_CNT) begin
        wr_total_r <= wr_total_r + 7'h01;
      end
      if (retx_go) begin
        rptr_r <= '0;
      end else if (rd_ok) begin
        rptr_r <= rptr_r + 6'h01;
      end
    end
  end

  // ----------------------------------------
  // Flags
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      full_flag_n <= 1'b1;
      empty_flag_n <= 1'b0;
      almost_full_flag_n <= 1'b1;
      almost_empty_flag_n <= 1'b0;
    end else begin
      full_flag_n <= full_nxt_n;
      empty_flag_n <= empty_nxt_n;
      // Sync mode freezes these until recovery has run out
      if (async_mode_r || !rtx_busy) begin
        almost_empty_flag_n <= ae_sel;
        almost_full_flag_n <= af_sel;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rtx_cnt_r <= 4'h0;
    end else if (retx_go) begin
      rtx_cnt_r <= RETRANSMIT_RECOVERY_CYC;
    end else if (rtx_busy) begin
      rtx_cnt_r <= rtx_cnt_r - 4'h1;
    end
  end

  // ----------------------------------------
  // Data out and cascade
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_data <= '0;
      rd_data_oe <= 1'b0;
      write_cascade_out <= 1'b0;
      read_cascade_out <= 1'b0;
    end else begin
      rd_data_oe <= ~out_disable_r;
      if (rd_ok) begin
        rd_data <= mem_r[rptr_r];
      end
      write_cascade_out <= wr_ok & (wptr_r == PTR_LAST);
      read_cascade_out <= rd_ok & (rptr_r == PTR_LAST);
    end
  end

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  always_comb begin
    irq_set = '0;
    irq_set[IRQ_FULL] = full_flag_n & ~full_nxt_n;
    irq_set[IRQ_EMPTY] = empty_flag_n & ~empty_nxt_n;
    irq_set[IRQ_AF] = almost_full_flag_n & ~af_sel & (async_mode_r | ~rtx_busy);
    irq_set[IRQ_AE] = almost_empty_flag_n & ~ae_sel & (async_mode_r | ~rtx_busy);
    irq_set[IRQ_OVF] = wr_en & ~full_flag_n;
    irq_set[IRQ_UNF] = rd_en & ~empty_flag_n;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_r <= '0;
      irq <= 1'b0;
    end else begin
      // A new event in the clearing cycle survives the clear
      if (ar_go && s_axi_araddr == OFS_IRQ_STATUS) begin
        irq_stat_r <= irq_set;
      end else begin
        irq_stat_r <= irq_stat_r | irq_set;
      end
      irq <= |(irq_stat_r & irq_mask_r);
    end
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      async_mode_r <= 1'b0;
      out_disable_r <= 1'b0;
      ae_off_r <= AE_OFS_RST;
      af_off_r <= AF_OFS_RST;
      irq_mask_r <= '0;
    end else if (do_wr && wstrb_r[0]) begin
      case (awaddr_r)
        OFS_CTRL: begin
          async_mode_r <= wdata_r[CTRL_ASYNC_BIT];
          out_disable_r <= wdata_r[CTRL_ODIS_BIT];
        end
        OFS_AE_OFFSET: ae_off_r <= byte0(ae_off_r, wdata_r, wstrb_r);
        OFS_AF_OFFSET: af_off_r <= byte0(af_off_r, wdata_r, wstrb_r);
        OFS_IRQ_MASK: irq_mask_r <= wdata_r[IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        awaddr_r <= {s_axi_awaddr[ADDR_W-1:2], 2'h0};
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        case (awaddr_r)
          OFS_CTRL, OFS_AE_OFFSET, OFS_AF_OFFSET, OFS_IRQ_MASK: s_axi_bresp <= RESP_OKAY;
          default: s_axi_bresp <= RESP_SLVERR;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      if (ar_go) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= '0;
        s_axi_rresp <= RESP_OKAY;
        case ({s_axi_araddr[ADDR_W-1:2], 2'h0})
          OFS_CTRL: begin
            s_axi_rdata[CTRL_ASYNC_BIT] <= async_mode_r;
            s_axi_rdata[CTRL_ODIS_BIT] <= out_disable_r;
          end
          OFS_AE_OFFSET: s_axi_rdata[CNT_W-1:0] <= ae_off_r;
          OFS_AF_OFFSET: s_axi_rdata[CNT_W-1:0] <= af_off_r;
          OFS_STATUS: begin
            s_axi_rdata[ST_EMPTY_N] <= empty_flag_n;
            s_axi_rdata[ST_AE_N] <= almost_empty_flag_n;
            s_axi_rdata[ST_AF_N] <= almost_full_flag_n;
            s_axi_rdata[ST_FULL_N] <= full_flag_n;
            s_axi_rdata[ST_RETX_BUSY] <= rtx_busy;
            s_axi_rdata[ST_CNT_LSB +: CNT_W] <= count_r;
          end
          OFS_IRQ_STATUS: s_axi_rdata[IRQ_W-1:0] <= irq_stat_r;
          OFS_IRQ_MASK: s_axi_rdata[IRQ_W-1:0] <= irq_mask_r;
          default: s_axi_rresp <= RESP_SLVERR;
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // dcf_fifo
`default_nettype wire

/* File: verif/dcf_fifo_assertions.sv */
/*
  Checker for dcf_fifo: flag, cascade and reset relations at the ports.
  Assumes one clock aclk and the synchronous active-low aresetn.
*/
`timescale 1ns/1ps
`default_nettype none
module dcf_fifo_assertions
  import dcf_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Stream side
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic full_flag_n,
  input wire logic almost_full_flag_n,
  input wire logic empty_flag_n,
  input wire logic almost_empty_flag_n,
  input wire logic write_cascade_out,
  input wire logic read_cascade_out,
  input wire logic [DATA_W-1:0] rd_data,
  input wire logic rd_data_oe
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_write_into_empty;
    !empty_flag_n ##0 wr_en;
  endsequence
  sequence s_read_from_full;
    !full_flag_n ##0 rd_en ##0 !wr_en;
  endsequence

  a_empty_clears: assert property (s_write_into_empty |=> empty_flag_n)
    else $error("empty flag held after write");
  a_full_clears: assert property (s_read_from_full |=> full_flag_n)
    else $error("full flag held after read");
  a_wcascade_cause: assert property (write_cascade_out |-> $past(wr_en) && $past(full_flag_n))
    else $error("write cascade without write");
  a_wcascade_pulse: assert property ($rose(write_cascade_out) |=> !write_cascade_out [*8])
    else $error("write cascade too long");
  a_rcascade_cause: assert property (read_cascade_out |-> $past(rd_en) && $past(empty_flag_n))
    else $error("read cascade without read");
  a_rcascade_pulse: assert property ($rose(read_cascade_out) |=> !read_cascade_out [*8])
    else $error("read cascade too long");
  a_full_almost: assert property (!full_flag_n [*5] |-> !almost_full_flag_n)
    else $error("full without almost full");
  a_empty_almost: assert property (!empty_flag_n [*2] |-> !almost_empty_flag_n)
    else $error("empty without almost empty");
  a_reset_outputs: assert property ($rose(aresetn) |-> rd_data == '0 && !empty_flag_n)
    else $error("outputs not cleared by reset");
  a_oe_after_reset: assert property ($rose(aresetn) |=> rd_data_oe)
    else $error("output drive not enabled after reset");
endmodule // dcf_fifo_assertions

bind dcf_fifo dcf_fifo_assertions dcf_fifo_assertions_i (.aclk, .aresetn, .wr_en, .rd_en,
  .full_flag_n, .almost_full_flag_n, .empty_flag_n, .almost_empty_flag_n,
  .write_cascade_out, .read_cascade_out, .rd_data, .rd_data_oe);
`default_nettype wire

/* File: verif/dcf_stream_model.sv */
/*
  Producer and consumer beside the FIFO: numbered words on request.
  Assumes the bench raises want_wr or want_rd at clock edges.
*/
`timescale 1ns/1ps
`default_nettype none
module dcf_stream_model
  import dcf_pkg::*;
(
  // Clock
  input wire logic aclk,
  // Bench commands
  input wire logic want_wr,
  input wire logic want_rd,
  // FIFO write side
  output logic wr_en,
  output logic [DATA_W-1:0] wr_data,
  input wire logic full_flag_n,
  // FIFO read side
  output logic rd_en
);
  logic [DATA_W-1:0] word_r = 18'h00001;
  initial wr_en = 1'b0;
  initial rd_en = 1'b0;
  // Idle data inverted so a stale word is never mistaken for a write
  assign wr_data = wr_en ? word_r : ~word_r;
  always @(posedge aclk) begin
    wr_en <= want_wr;
    rd_en <= want_rd;
    if (wr_en && full_flag_n) begin
      word_r <= word_r + 18'h00001;
    end
  end
endmodule // dcf_stream_model
`default_nettype wire

/* File: verif/dcf_fifo_test.sv */
/*
  Bench for dcf_fifo: stream traffic via the model, registers via AXI4-Lite.
  Assumes dcf_pkg constants and a 200 MHz aclk.
*/
`timescale 1ns/1ps
`default_nettype none
module dcf_fifo_test
  import dcf_pkg::*;
;
  logic aclk, aresetn, want_wr, want_rd, wr_en, rd_en, irq, oe, wco, rco, rd_took;
  logic full_n, afull_n, empty_n, aempty_n;
  logic [DATA_W-1:0] wr_data, rd_data, exp_word;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata, v;
  logic [1:0] bresp, rresp, r;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  int num_errors = 0;
  int n_compared = 0;
  int wco_seen = 0;
  int rco_seen = 0;

  dcf_fifo dcf_fifo_i (.aclk(aclk), .aresetn(aresetn), .wr_en(wr_en), .wr_data(wr_data),
    .full_flag_n(full_n), .almost_full_flag_n(afull_n), .write_cascade_out(wco),
    .rd_en(rd_en), .rd_data(rd_data), .rd_data_oe(oe), .empty_flag_n(empty_n),
    .almost_empty_flag_n(aempty_n), .read_cascade_out(rco), .irq(irq),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  dcf_stream_model dcf_stream_model_i (.aclk(aclk), .want_wr(want_wr), .want_rd(want_rd),
    .wr_en(wr_en), .wr_data(wr_data), .full_flag_n(full_n), .rd_en(rd_en));

  // ----------------------------------------
  // Checking and reporting
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Bus and stream tasks
  // ----------------------------------------
  task automatic axi_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [ADDR_W-1:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    v = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] e, input logic [1:0] er);
    axi_rd(a);
    chk(v, e);
    chk(32'(r), 32'(er));
  endtask
  // Model lags one edge, so two spare edges let the last op land
  task automatic stream(input logic ww, input logic rr, input int n);
    @(posedge aclk);
    want_wr <= ww;
    want_rd <= rr;
    repeat (n) @(posedge aclk);
    want_wr <= 1'b0;
    want_rd <= 1'b0;
    repeat (2) @(posedge aclk);
    #1;
  endtask

  // Read data follows each accepted read by one edge
  always @(posedge aclk) begin
    if (wco === 1'b1) wco_seen++;
    if (rco === 1'b1) rco_seen++;
    if (rd_took === 1'b1) begin
      chk(32'(rd_data), 32'(exp_word));
      exp_word = exp_word + 18'h00001;
    end
    rd_took <= rd_en && empty_n;
  end

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  initial begin
    repeat (5000) @(posedge aclk);
    num_errors++;
    summarize();
  end

  initial begin
    {aresetn, want_wr, want_rd, awvalid, wvalid, bready, arvalid, rready, rd_took} = '0;
    {awaddr, araddr, wdata} = '0;
    exp_word = 18'h00001;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    #1;
    chk({oe, empty_n, aempty_n, full_n, afull_n, 9'h0, rd_data}, 32'h98000000);
    rd_chk(OFS_CTRL, 32'h0, RESP_OKAY);
    rd_chk(OFS_AE_OFFSET, 32'h8, RESP_OKAY);
    rd_chk(OFS_AF_OFFSET, 32'h8, RESP_OKAY);
    rd_chk(OFS_IRQ_MASK, 32'h0, RESP_OKAY);
    rd_chk(8'h18, 32'h0, RESP_SLVERR);
    axi_wr(8'h18, 32'h1);
    chk(32'(r), 32'(RESP_SLVERR));
    axi_wr(OFS_STATUS, 32'h0);
    chk(32'(r), 32'(RESP_SLVERR));
    stream(1'b1, 1'b0, 1);
    chk(32'(empty_n), 32'h1);
    stream(1'b0, 1'b1, 1);
    chk(32'(empty_n), 32'h0);
    stream(1'b1, 1'b0, 7);
    chk(32'(aempty_n), 32'h0);
    stream(1'b1, 1'b0, 1);
    chk(32'(aempty_n), 32'h1);
    rd_chk(OFS_STATUS, 32'h0000080F, RESP_OKAY);
    stream(1'b1, 1'b0, 48);
    chk(32'(afull_n), 32'h1);
    stream(1'b1, 1'b0, 1);
    chk(32'(afull_n), 32'h0);
    stream(1'b1, 1'b0, 8);
    chk({full_n, 31'(wco_seen)}, 32'h1);
    rd_chk(OFS_STATUS, 32'h00004003, RESP_OKAY);
    chk(32'(irq), 32'h0);
    axi_wr(OFS_IRQ_MASK, 32'h3F);
    repeat (2) @(posedge aclk);
    #1;
    chk(32'(irq), 32'h1);
    rd_chk(OFS_IRQ_STATUS, 32'h17, RESP_OKAY);
    rd_chk(OFS_IRQ_STATUS, 32'h0, RESP_OKAY);
    repeat (2) @(posedge aclk);
    #1;
    chk(32'(irq), 32'h0);
    stream(1'b0, 1'b1, 1);
    chk(32'(full_n), 32'h1);
    stream(1'b0, 1'b1, 56);
    chk(32'(aempty_n), 32'h0);
    stream(1'b0, 1'b1, 7);
    chk({empty_n, 31'(rco_seen)}, 32'h1);
    axi_wr(OFS_CTRL, 32'h4);
    repeat (RETRANSMIT_RECOVERY_CYC + 2) @(posedge aclk);
    #1;
    chk({30'h0, full_n, empty_n}, 32'h1);
    rd_chk(OFS_STATUS, 32'h00004003, RESP_OKAY);
    exp_word = 18'h00041;
    stream(1'b0, 1'b1, 1);
    chk(32'(full_n), 32'h1);
    // Async flag mode; replay continues from location 1
    axi_wr(OFS_CTRL, 32'h1);
    exp_word = 18'h00002;
    stream(1'b0, 1'b1, 56);
    chk({30'h0, aempty_n, afull_n}, 32'h1);
    axi_wr(OFS_CTRL, 32'h2);
    repeat (2) @(posedge aclk);
    #1;
    chk(32'(oe), 32'h0);
    summarize();
  end
endmodule // dcf_fifo_test
`default_nettype wire
